//--- rtl/efi_unit.sv
// Event flag and interrupt unit with APB register access
// What this block does
// - Interrupt pin is open drain, pulled low to request, else released high.
// - Interrupt requests only in start-up, normal, standby and flash modes.
// - CAN, LIN, local and timer wake flags interrupt whatever the mask holds; they have no mask.
// - Every event sets its flag; a low mask bit blocks the interrupt.
// - A flag stays set until a read-and-clear of its status word; reset mode also clears non-wake flags.
// - Unmasked pending events give width pulses spaced at least the gap.
// - Flags survive start-up/standby to normal and normal to standby.
// - Standby request with pending unmasked interrupt gives a fresh pulse.
// - Sleep request with pending wake flag triggers wakeup-from-sleep.
// - Reset mode clears all non-wake flags and masks every maskable event.
// - Tx held low past timeout in transceiver normal mode sets timeout flag.
// - Converter flags set on every change of their four status bits.
// - Thermal warning flag set on each warning-threshold crossing.
// - Aux undervoltage flags only when aux on; overvoltage on any change.
// - Devmode watchdog fail sets flag and gives one pulse per event.
// - Serial frame error flag set on bad clock count or clock-high select edge.
// - Wake flags need enabled sources; cleared by reading status word b.
// - Live status bits stay readable any time, independent of flags.
// - LIN tx timeout detection can be switched on or off by software.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module efi_unit #(
  parameter int PulseCycles = efi_pkg::PULSE_CYCLES,
  parameter int GapCycles = efi_pkg::GAP_CYCLES,
  parameter int TxToCycles = efi_pkg::TX_TO_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire efi_pkg::efi_mode_e opMode,
  input wire logic canNormal,
  input wire logic lin1Normal,
  input wire logic lin2Normal,
  input wire logic swDevCfg,
  input wire logic wdFail,
  input wire logic serialFrameErr,
  input wire logic sleepReq,
  input wire logic standbyReq,
  input wire efi_pkg::efi_det_s detIn,
  input wire efi_pkg::efi_wake_s wakeIn,
  output logic irqOutN,
  output logic irqOeN,
  output logic wakeFromSleep
);
  localparam int CW = 16;
  localparam int TW = $clog2(TxToCycles + 1);

  initial begin
    if (PulseCycles < 1 || PulseCycles >= 2 ** CW) $error("PulseCycles out of range");
    if (GapCycles < 1 || GapCycles >= 2 ** CW) $error("GapCycles out of range");
    if (TxToCycles < 1) $error("TxToCycles out of range");
  end

  typedef struct packed {
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [9:0] prev;
    logic [efi_pkg::FLAG_W-1:0] flagsA;
    logic [efi_pkg::WAKE_W-1:0] wake;
    logic [efi_pkg::FLAG_W-1:0] mask;
    logic [efi_pkg::CTRL_W-1:0] ctrl;
    logic [2:0][TW-1:0] toCnt;
    efi_pkg::efi_irq_e st;
    logic [CW-1:0] cnt;
    logic wdPend;
    logic kick;
    logic wakeSleep;
    logic oeN;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
  } efi_state_s;

  localparam efi_state_s STATE_RST = '{
    sync1: 10'h000, sync2: 10'h000, prev: 10'h000,
    flagsA: 12'h000, wake: 5'h00, mask: efi_pkg::MASK_RST,
    ctrl: efi_pkg::CTRL_RST, toCnt: '0, st: efi_pkg::IRQ_IDLE,
    cnt: 16'h0000, wdPend: 1'b0, kick: 1'b0, wakeSleep: 1'b0,
    oeN: 1'b1, rdata: 32'h0000_0000, ready: 1'b0, slvErr: 1'b0};

  logic rstMeta;
  logic rstSync;
  efi_state_s q;
  efi_state_s n;

  // Reset released through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  function automatic logic isOfs(input logic [7:0] a, input logic [7:0] ofs);
    isOfs = (a[7:2] == ofs[7:2]);
  endfunction : isOfs

  logic modeOk;
  logic busDone;
  logic clrA;
  logic clrB;
  logic pendAny;
  logic [2:0] txActive;
  logic [2:0] toHit;
  logic [efi_pkg::FLAG_W-1:0] setA;
  logic [efi_pkg::WAKE_W-1:0] setB;
  logic [9:0] chg;
  logic [31:0] liveWord;

  always_comb begin
    n = q;
    modeOk = (opMode == efi_pkg::MODE_STARTUP) || (opMode == efi_pkg::MODE_NORMAL) ||
             (opMode == efi_pkg::MODE_STANDBY) || (opMode == efi_pkg::MODE_FLASH);
    // First stage feeds only the second
    n.sync1 = detIn;
    n.sync2 = q.sync1;
    n.prev = q.sync2;
    chg = q.sync2 ^ q.prev;

    // Transmit dominant timeout counters, saturating at the limit
    txActive[0] = !q.sync2[7] && canNormal;
    txActive[1] = !q.sync2[8] && lin1Normal && q.ctrl[efi_pkg::BIT_LIN1_TO_EN];
    txActive[2] = !q.sync2[9] && lin2Normal && q.ctrl[efi_pkg::BIT_LIN2_TO_EN];
    for (int i = 0; i < 3; i++) begin
      if (!txActive[i]) begin
        n.toCnt[i] = '0;
      end else if (q.toCnt[i] != TW'(TxToCycles)) begin
        n.toCnt[i] = q.toCnt[i] + TW'(1);
      end
      toHit[i] = (q.toCnt[i] == TW'(TxToCycles));
    end

    // Event sets, independent of masking
    setA = '0;
    setA[2:0] = toHit;
    setA[6:3] = chg[3:0];
    setA[7] = chg[4];
    setA[efi_pkg::BIT_WD_FAIL] = wdFail && swDevCfg;
    setA[efi_pkg::BIT_AUX_UV] = chg[5] && q.ctrl[efi_pkg::BIT_AUX_ON];
    setA[10] = chg[6];
    // Spurious frame errors at power-up are left for software to discard
    setA[efi_pkg::BIT_SER_ERR] = serialFrameErr;
    setB = wakeIn & q.ctrl[efi_pkg::WAKE_W-1:0];

    // APB: answer one cycle into the access phase; data captured for clear
    busDone = psel && penable && q.ready;
    clrA = busDone && !pwrite && isOfs(paddr, efi_pkg::OFS_STAT_A);
    clrB = busDone && !pwrite && isOfs(paddr, efi_pkg::OFS_STAT_B);
    liveWord = {22'h00_0000, 3'b000, q.sync2[6:0]};
    n.ready = psel && penable && !q.ready;
    n.slvErr = 1'b0;
    n.rdata = q.rdata;
    if (psel && penable && !q.ready) begin
      if (isOfs(paddr, efi_pkg::OFS_STAT_A)) begin
        n.rdata = {20'h0_0000, q.flagsA};
      end else if (isOfs(paddr, efi_pkg::OFS_STAT_B)) begin
        n.rdata = {27'h000_0000, q.wake};
      end else if (isOfs(paddr, efi_pkg::OFS_MASK)) begin
        n.rdata = {20'h0_0000, q.mask};
      end else if (isOfs(paddr, efi_pkg::OFS_CTRL)) begin
        n.rdata = {24'h00_0000, q.ctrl};
      end else if (isOfs(paddr, efi_pkg::OFS_LIVE)) begin
        n.rdata = liveWord;
      end else begin
        n.rdata = 32'h0000_0000;
        n.slvErr = 1'b1;
      end
    end
    if (busDone && pwrite) begin
      if (isOfs(paddr, efi_pkg::OFS_MASK)) begin
        n.mask = pwdata[efi_pkg::FLAG_W-1:0];
      end
      if (isOfs(paddr, efi_pkg::OFS_CTRL)) begin
        n.ctrl = pwdata[efi_pkg::CTRL_W-1:0];
      end
    end

    // Clear only what was read; a set in the same cycle wins
    n.flagsA = q.flagsA;
    if (clrA) begin
      n.flagsA = q.flagsA & ~q.rdata[efi_pkg::FLAG_W-1:0];
    end
    n.flagsA = n.flagsA | setA;
    n.wake = q.wake;
    if (clrB) begin
      n.wake = q.wake & ~q.rdata[efi_pkg::WAKE_W-1:0];
    end
    n.wake = n.wake | setB;
    // Only reset mode clears and masks; other mode changes keep flags
    if (opMode == efi_pkg::MODE_RESET) begin
      n.flagsA = '0;
      n.mask = efi_pkg::MASK_RST;
    end

    // Watchdog fail is a one-shot request, not a level
    pendAny = |(q.flagsA & q.mask & ~(12'h001 << efi_pkg::BIT_WD_FAIL)) || (|q.wake);
    if (setA[efi_pkg::BIT_WD_FAIL] && q.mask[efi_pkg::BIT_WD_FAIL]) begin
      n.wdPend = 1'b1;
    end
    if (standbyReq && pendAny) begin
      n.kick = 1'b1;
    end

    n.wakeSleep = sleepReq && (|q.wake);

    // Pulse timer; pending level keeps retriggering until software clears
    case (q.st)
      efi_pkg::IRQ_IDLE: begin
        if (modeOk && (pendAny || q.wdPend || q.kick)) begin
          n.st = efi_pkg::IRQ_PULSE;
          n.cnt = CW'(PulseCycles - 1);
          n.wdPend = 1'b0;
          n.kick = 1'b0;
        end
      end
      efi_pkg::IRQ_PULSE: begin
        if (q.cnt == '0) begin
          n.st = efi_pkg::IRQ_GAP;
          n.cnt = CW'(GapCycles - 1);
        end else begin
          n.cnt = q.cnt - CW'(1);
        end
      end
      efi_pkg::IRQ_GAP: begin
        if (q.cnt == '0) begin
          n.st = efi_pkg::IRQ_IDLE;
        end else begin
          n.cnt = q.cnt - CW'(1);
        end
      end
      default: begin
        n.st = efi_pkg::IRQ_IDLE;
      end
    endcase
    // Leaving an allowed mode drops a pulse in progress
    if (!modeOk && q.st == efi_pkg::IRQ_PULSE) begin
      n.st = efi_pkg::IRQ_GAP;
      n.cnt = CW'(GapCycles - 1);
    end
    n.oeN = !(n.st == efi_pkg::IRQ_PULSE);
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slvErr;
  assign irqOutN = 1'b0;
  assign irqOeN = q.oeN;
  assign wakeFromSleep = q.wakeSleep;

  // Helper run counters for pulse timing checks
  logic [CW:0] lowRun;
  logic [CW:0] highRun;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      lowRun <= '0;
      highRun <= '1;
    end else begin
      lowRun <= q.oeN ? '0 : lowRun + (CW+1)'(1);
      highRun <= !q.oeN ? '0 : ((&highRun) ? highRun : highRun + (CW+1)'(1));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync);

  a_irq_mode_gate: assert property (!irqOeN |-> $past(modeOk))
    else $error("Interrupt driven outside allowed mode");
  // Run counter already holds the full low count at the rising edge
  a_pulse_width_exact: assert property ($rose(irqOeN) && $past(modeOk)
    |-> lowRun == (CW+1)'(PulseCycles))
    else $error("Interrupt pulse width wrong");
  a_pulse_gap_min: assert property ($fell(irqOeN)
    |-> $past(highRun) >= (CW+1)'(GapCycles))
    else $error("Interrupt gap too short");
  a_masked_stays_quiet: assert property (q.st == efi_pkg::IRQ_IDLE && !pendAny
    && !q.wdPend && !q.kick |=> irqOeN)
    else $error("Pulse without unmasked request");
  a_reset_mode_clear: assert property (opMode == efi_pkg::MODE_RESET
    |=> q.flagsA == '0 && q.mask == efi_pkg::MASK_RST)
    else $error("Reset mode left flags or masks");
  a_wake_flags_kept: assert property (!clrB |=> (q.wake & $past(q.wake)) == $past(q.wake))
    else $error("Wake flag lost without clear");
  a_standby_kick: assert property (standbyReq && pendAny
    |=> q.kick || q.st == efi_pkg::IRQ_PULSE)
    else $error("Standby request with pending interrupt not kicked");
  a_timeout_persists: assert property (toHit[0] && clrA && opMode != efi_pkg::MODE_RESET
    |=> q.flagsA[efi_pkg::BIT_CAN_TO])
    else $error("Timeout flag cleared while dominant");
  a_sleep_wakeup: assert property (sleepReq && (|q.wake) |=> wakeFromSleep)
    else $error("Sleep with pending wake not rejected");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  c_pulse_seen: cover property ($fell(irqOeN) ##[1:1000] $rose(irqOeN));
  c_timeout_set: cover property ($rose(q.flagsA[efi_pkg::BIT_CAN_TO]));
  c_status_clear: cover property (clrA && (|q.flagsA));
  c_standby_kick: cover property (standbyReq && pendAny);
endmodule : efi_unit

//--- inc/efi_pkg.sv
// Constants, types and register map of the event flag and interrupt unit
package efi_pkg;
  // Clock rate and documented timing in their own units
  localparam int CLK_HZ = 10_000_000;
  localparam int PULSE_WIDTH_US = 100;
  localparam int PULSE_GAP_US = 1000;
  localparam int TX_TIMEOUT_US = 1000;
  // Width rounds down, gap and timeout round up
  localparam int PULSE_CYCLES = PULSE_WIDTH_US * (CLK_HZ / 1_000_000);
  localparam int GAP_CYCLES = (PULSE_GAP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int TX_TO_CYCLES = (TX_TIMEOUT_US * (CLK_HZ / 1000) + 999) / 1000;

  // APB register byte offsets
  localparam logic [7:0] OFS_STAT_A = 8'h00;
  localparam logic [7:0] OFS_STAT_B = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LIVE = 8'h10;

  // Bit positions in event_status_word_a and the mask register
  localparam int BIT_CAN_TO = 0;
  localparam int BIT_LIN1_TO = 1;
  localparam int BIT_LIN2_TO = 2;
  localparam int BIT_SD_UNREG = 3;
  localparam int BIT_WD_FAIL = 8;
  localparam int BIT_AUX_UV = 9;
  localparam int BIT_SER_ERR = 11;
  localparam int FLAG_W = 12;
  localparam int WAKE_W = 5;
  // Control word: wake enables [4:0], LIN timeout enables [6:5], aux on [7]
  localparam int BIT_LIN1_TO_EN = 5;
  localparam int BIT_LIN2_TO_EN = 6;
  localparam int BIT_AUX_ON = 7;
  localparam int CTRL_W = 8;

  localparam logic [11:0] MASK_RST = 12'h000;
  localparam logic [7:0] CTRL_RST = 8'h7F;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'b000,
    MODE_STARTUP = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_STANDBY = 3'b011,
    MODE_FLASH = 3'b100,
    MODE_RESET = 3'b101,
    MODE_SLEEP = 3'b110,
    MODE_FAILSAFE = 3'b111
  } efi_mode_e;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_GAP = 2'b10
  } efi_irq_e;

  // Raw detector levels, from outside this clock domain; tx lines low = dominant
  typedef struct packed {
    logic lin2TxIn;
    logic lin1TxIn;
    logic canTxIn;
    logic auxOv;
    logic auxUv;
    logic thermWarn;
    logic stepupOverload;
    logic stepupRunning;
    logic stepdownOverload;
    logic stepdownUnregulated;
  } efi_det_s;

  // One-cycle wake events from same-clock logic
  typedef struct packed {
    logic timerWake;
    logic lin2Wake;
    logic lin1Wake;
    logic canWake;
    logic localWake;
  } efi_wake_s;
endpackage : efi_pkg

//--- testbench/efi_mcu_model.sv
// Microcontroller side of the interrupt pin: pull-up and pulse timing
`timescale 1ns/1ps
module efi_mcu_model (
  input wire logic core_clk,
  input wire logic irqOutN,
  input wire logic irqOeN,
  output logic irqLine,
  output int pulseCount,
  output int pulseWidth,
  output int pulseGap
);
  int lowRun = 0;
  int highRun = 0;
  // Released pin reads high through the pull-up
  assign irqLine = irqOeN ? 1'b1 : irqOutN;
  initial begin
    pulseCount = 0;
    pulseWidth = 0;
    pulseGap = 0;
  end
  always @(posedge core_clk) begin
    if (irqLine === 1'b0) begin
      if (lowRun == 0) begin
        pulseCount <= pulseCount + 1;
        pulseGap <= highRun;
      end
      lowRun <= lowRun + 1;
      highRun <= 0;
    end else begin
      if (lowRun != 0) pulseWidth <= lowRun;
      lowRun <= 0;
      highRun <= highRun + 1;
    end
  end
endmodule : efi_mcu_model

//--- testbench/tb_efi_unit.sv
// Self-checking bench for the event flag and interrupt unit
`timescale 1ns/1ps
module tb_efi_unit;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic canNormal, lin1Normal, lin2Normal, swDevCfg, wdFail, serialFrameErr;
  logic sleepReq, standbyReq, irqOutN, irqOeN, wakeFromSleep, irqLine;
  efi_pkg::efi_mode_e opMode;
  efi_pkg::efi_det_s detIn;
  efi_pkg::efi_wake_s wakeIn;
  int pulseCount, pulseWidth, pulseGap, n0, cycles = 0;
  int fail_count = 0;
  int samples_checked = 0;

  // Short counts keep the run brief
  efi_unit #(.PulseCycles(4), .GapCycles(6), .TxToCycles(8)) efi_unit_inst (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opMode(opMode), .canNormal(canNormal), .lin1Normal(lin1Normal),
    .lin2Normal(lin2Normal), .swDevCfg(swDevCfg), .wdFail(wdFail),
    .serialFrameErr(serialFrameErr), .sleepReq(sleepReq), .standbyReq(standbyReq),
    .detIn(detIn), .wakeIn(wakeIn), .irqOutN(irqOutN), .irqOeN(irqOeN),
    .wakeFromSleep(wakeFromSleep));
  efi_mcu_model efi_mcu_model_inst (.core_clk(core_clk), .irqOutN(irqOutN),
    .irqOeN(irqOeN), .irqLine(irqLine), .pulseCount(pulseCount),
    .pulseWidth(pulseWidth), .pulseGap(pulseGap));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer and data taken at the edge that samples pready high
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd

  // Bits: sleep, standby, watchdog, serial error, wake sources
  task automatic evt(input logic [8:0] v);
    @(posedge core_clk);
    {sleepReq, standbyReq, wdFail, serialFrameErr, wakeIn} <= v;
    @(posedge core_clk);
    {sleepReq, standbyReq, wdFail, serialFrameErr, wakeIn} <= 9'h000;
  endtask : evt

  task automatic t_regs;
    rd(efi_pkg::OFS_MASK, 32'h0000_0000);
    rd(efi_pkg::OFS_CTRL, 32'h0000_007F);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(rerr, 1'b1);
    apb(1'b1, efi_pkg::OFS_LIVE, 32'h0000_007F);
    rd(efi_pkg::OFS_LIVE, 32'h0000_0000);
  endtask : t_regs

  task automatic t_serial;
    n0 = pulseCount;
    evt(9'h020);
    repeat (12) @(posedge core_clk);
    chk(pulseCount, n0);
    // Reading status once clears the serial error raised above while its mask bit was low
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0800);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0000);
    apb(1'b1, efi_pkg::OFS_MASK, 32'h0000_0800);
    evt(9'h020);
    repeat (24) @(posedge core_clk);
    chk(pulseCount >= n0 + 2, 1'b1);
    chk(pulseWidth, 4);
    chk(pulseGap >= 6, 1'b1);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0800);
    repeat (12) @(posedge core_clk);
    n0 = pulseCount;
    repeat (30) @(posedge core_clk);
    chk(pulseCount, n0);
  endtask : t_serial

  task automatic t_wd;
    apb(1'b1, efi_pkg::OFS_MASK, 32'h0000_0100);
    n0 = pulseCount;
    evt(9'h040);
    repeat (30) @(posedge core_clk);
    chk(pulseCount - n0, 1);
    // Watchdog request is a one-shot, so standby must not revive it
    evt(9'h080);
    repeat (15) @(posedge core_clk);
    chk(pulseCount - n0, 1);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0100);
  endtask : t_wd

  task automatic t_wake;
    opMode <= efi_pkg::MODE_SHUTDOWN;
    n0 = pulseCount;
    evt(9'h002);
    repeat (12) @(posedge core_clk);
    chk(pulseCount, n0);
    opMode <= efi_pkg::MODE_NORMAL;
    repeat (10) @(posedge core_clk);
    chk(pulseCount - n0, 1);
    evt(9'h100);
    #1;
    chk(wakeFromSleep, 1'b1);
    // Standby request while the wake flag is pending
    evt(9'h080);
    repeat (20) @(posedge core_clk);
    chk(pulseCount - n0 >= 2, 1'b1);
    rd(efi_pkg::OFS_STAT_B, 32'h0000_0002);
    rd(efi_pkg::OFS_STAT_B, 32'h0000_0000);
    apb(1'b1, efi_pkg::OFS_CTRL, 32'h0000_007D);
    evt(9'h002);
    rd(efi_pkg::OFS_STAT_B, 32'h0000_0000);
  endtask : t_wake

  task automatic t_therm;
    detIn.thermWarn <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(efi_pkg::OFS_LIVE, 32'h0000_0010);
    opMode <= efi_pkg::MODE_STANDBY;
    repeat (3) @(posedge core_clk);
    opMode <= efi_pkg::MODE_NORMAL;
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0080);
    detIn.thermWarn <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0080);
  endtask : t_therm

  task automatic t_txto;
    detIn.canTxIn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0001);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0001);
    detIn.canTxIn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0001);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0000);
    apb(1'b1, efi_pkg::OFS_CTRL, 32'h0000_005F);
    detIn.lin1TxIn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0000);
    detIn.lin1TxIn <= 1'b1;
  endtask : t_txto

  task automatic t_rstmode;
    apb(1'b1, efi_pkg::OFS_MASK, 32'h0000_0FFF);
    detIn.auxOv <= 1'b1;
    detIn.auxUv <= 1'b1;
    evt(9'h001);
    repeat (6) @(posedge core_clk);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0400);
    detIn.auxOv <= 1'b0;
    repeat (6) @(posedge core_clk);
    opMode <= efi_pkg::MODE_RESET;
    repeat (3) @(posedge core_clk);
    opMode <= efi_pkg::MODE_NORMAL;
    rd(efi_pkg::OFS_MASK, 32'h0000_0000);
    rd(efi_pkg::OFS_STAT_A, 32'h0000_0000);
    rd(efi_pkg::OFS_STAT_B, 32'h0000_0001);
  endtask : t_rstmode

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, wdFail, serialFrameErr, sleepReq, standbyReq} = 7'h00;
    {canNormal, lin1Normal, lin2Normal, swDevCfg} = 4'hF;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    opMode = efi_pkg::MODE_NORMAL;
    detIn = efi_pkg::efi_det_s'(10'h380);
    wakeIn = efi_pkg::efi_wake_s'(5'h00);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_serial();
    t_wd();
    t_wake();
    t_therm();
    t_txto();
    t_rstmode();
    give_verdict();
  end
endmodule : tb_efi_unit
